/* fsl_consts.svh */
// Constants for the fieldbus node configuration and status LED block.
// Assumes a 10 MHz core clock and a millisecond timebase derived from it.
// Overview of operation
// - Settings change only when motor stopped, locked.
// - New settings apply only after power cycle.
// - Address 0..127, default 0; zero disables comms.
// - Seven bit rates, default 125 kbit/s, shared.
// - Run LED off when off, single-flash when stopped.
// - Run LED blinks pre-operational, on when operational.
// - Error LED double-flash on guarding, on bus-off.
// - Single flash: short on, then 1 s off.
// - Double flash: on, 200 ms off, on, 1 s off.
`ifndef FSL_CONSTS_SVH
`define FSL_CONSTS_SVH

`define FSL_CLK_HZ 10000000
`define FSL_TICK_MS 1
`define FSL_MS_CYCLES (`FSL_CLK_HZ / 1000 * `FSL_TICK_MS)
`define FSL_PHASE_MS 200
`define FSL_GAP_MS 1000
`define FSL_ADDR_RESET 7'h00
`define FSL_ADDR_MAX 7'h7F
`define FSL_RATE_RESET 3'h3

`endif

/* fsl_pkg.sv */
// Types for the fieldbus node configuration and status LED block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fsl_pkg;
	typedef enum logic [2:0] {
		FSL_RATE_10K, FSL_RATE_20K, FSL_RATE_50K, FSL_RATE_125K,
		FSL_RATE_250K, FSL_RATE_500K, FSL_RATE_1000K
	} fsl_rate_t;
	typedef enum logic [1:0] {
		FSL_NMT_OFF, FSL_NMT_STOPPED, FSL_NMT_PREOP, FSL_NMT_OPER
	} fsl_nmt_t;
	typedef enum logic [2:0] {
		FSL_PAT_OFF, FSL_PAT_SINGLE, FSL_PAT_DOUBLE, FSL_PAT_BLINK, FSL_PAT_ON
	} fsl_pat_t;
endpackage
`default_nettype wire

/* fsl_led_pattern.sv */
// Pattern generator for one status LED.
// Assumes a one-cycle millisecond tick on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "fsl_consts.svh"
module fsl_led_pattern
	import fsl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ms_tick,
	input wire fsl_pat_t pattern,
	output logic led
);
	// Cycle is phase-slot based: 200 ms slots, then the 1 s gap.
	localparam logic [11:0] PHASE_MS = 12'(`FSL_PHASE_MS);
	localparam logic [11:0] GAP_MS = 12'(`FSL_GAP_MS);
	logic [11:0] ms_reg;
	logic [1:0] slot_reg;
	logic led_reg;
	fsl_pat_t pat_reg;
	wire logic is_flash = (pattern == FSL_PAT_SINGLE) || (pattern == FSL_PAT_DOUBLE);
	// Blinking shares the two-slot cycle of the single flash, without the gap.
	wire logic two_slot = (pattern == FSL_PAT_SINGLE) || (pattern == FSL_PAT_BLINK);
	wire logic last_slot = two_slot ? (slot_reg == 2'd1) :
		(pattern == FSL_PAT_DOUBLE) ? (slot_reg == 2'd3) : 1'b1;
	wire logic [11:0] slot_len = (is_flash && last_slot) ? GAP_MS : PHASE_MS;
	wire logic slot_done = ms_tick && (ms_reg == slot_len - 12'd1);
	wire logic changed = (pattern != pat_reg);
	wire logic [1:0] slot_next = last_slot ? 2'd0 : slot_reg + 2'd1;
	wire logic led_next =
		(pattern == FSL_PAT_ON) ? 1'b1 :
		(pattern == FSL_PAT_OFF) ? 1'b0 :
		(pattern == FSL_PAT_BLINK) ? ~slot_reg[0] :
		~slot_reg[0] && !(is_flash && last_slot);

	always_ff @(posedge core_clk) begin
		if (rst || changed) begin
			ms_reg <= 12'd0;
			slot_reg <= 2'd0;
		end else if (slot_done) begin
			ms_reg <= 12'd0;
			slot_reg <= slot_next;
		end else if (ms_tick) begin
			ms_reg <= ms_reg + 12'd1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pat_reg <= FSL_PAT_OFF;
			led_reg <= 1'b0;
		end else begin
			pat_reg <= pattern;
			led_reg <= changed ? 1'b0 : led_next;
		end
	end

	assign led = led_reg;
endmodule // fsl_led_pattern
`default_nettype wire

/* fsl_fieldbus_status.sv */
// Fieldbus node configuration holding and front-panel LED status block.
// Assumes controller state inputs on core_clk; panel inputs are asynchronous.
// The blinking and flashing patterns come from fsl_led_pattern.
`timescale 1ns/1ps
`default_nettype none
`include "fsl_consts.svh"
module fsl_fieldbus_status
	import fsl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic motor_stopped,
	input wire logic drive_locked,
	input wire logic cfg_write,
	input wire logic [6:0] node_address_setting,
	input wire logic [2:0] rate_setting,
	input wire fsl_nmt_t nmt_state,
	input wire logic err_warning,
	input wire logic err_guard_event,
	input wire logic err_guard_clear,
	input wire logic err_bus_off,
	output logic [6:0] active_address,
	output logic [2:0] active_rate,
	output logic comm_enable,
	output logic [6:0] pending_address,
	output logic [2:0] pending_rate,
	output logic cfg_pending,
	output logic cfg_rejected,
	output logic run_led,
	output logic err_led
);
	// ----------------------------------------------------------------
	// Panel input synchronisers
	// ----------------------------------------------------------------
	// The three panel levels come from outside the core clock domain; each
	// passes two flip-flops, and nothing but the second stage is read.
	localparam int SYNC_W = 3;
	wire logic [SYNC_W-1:0] panel_pins = {cfg_write, drive_locked, motor_stopped};
	wire logic [SYNC_W-1:0] synced;
	generate
		for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_sync
			logic first_reg, second_reg;
			always_ff @(posedge core_clk) begin
				if (rst) begin
					first_reg <= 1'b0;
					second_reg <= 1'b0;
				end else begin
					first_reg <= panel_pins[gi];
					second_reg <= first_reg;
				end
			end
			assign synced[gi] = second_reg;
		end
	endgenerate
	wire logic stop_sync = synced[0];
	wire logic lock_sync = synced[1];
	wire logic wr_sync = synced[2];

	// The edge detector idles low like the strobe pin, so reset makes no edge.
	logic wr_prev_reg;
	always_ff @(posedge core_clk) begin
		if (rst)
			wr_prev_reg <= 1'b0;
		else
			wr_prev_reg <= wr_sync;
	end

	// ----------------------------------------------------------------
	// Write request decode
	// ----------------------------------------------------------------
	// Address and rate are sampled on the write edge after two stages of the
	// strobe; software must hold them steady around the strobe.
	wire logic wr_edge = wr_sync && !wr_prev_reg;
	wire logic cfg_allowed = stop_sync && lock_sync;
	wire logic rate_legal = rate_setting <= 3'(FSL_RATE_1000K);
	// Seven bits cannot exceed the top address; the compare names the limit.
	wire logic addr_legal = node_address_setting <= `FSL_ADDR_MAX;
	wire logic accept = wr_edge && cfg_allowed && rate_legal && addr_legal;

	// ----------------------------------------------------------------
	// Pending and running configuration
	// ----------------------------------------------------------------
	// The pending copy stands for the drive's non-volatile settings store, so
	// rst, which models the power cycle, leaves it alone and it starts from
	// the defaults. The running copy reads it only at the first edge after
	// rst, which keeps a new setting off the bus until the next power cycle.
	logic [6:0] pend_addr_reg = `FSL_ADDR_RESET;
	logic [2:0] pend_rate_reg = `FSL_RATE_RESET;
	logic [6:0] run_addr_reg;
	logic [2:0] run_rate_reg;
	logic pend_reg, rej_reg, boot_reg;
	always_ff @(posedge core_clk) begin
		if (accept && !rst)
			pend_addr_reg <= node_address_setting;
	end

	always_ff @(posedge core_clk) begin
		if (accept && !rst)
			pend_rate_reg <= rate_setting;
	end

	// A power cycle applies whatever was pending, so the flag starts clear.
	always_ff @(posedge core_clk) begin
		if (rst)
			pend_reg <= 1'b0;
		else if (accept)
			pend_reg <= 1'b1;
	end

	// Every write attempt leaves its verdict here until the next one.
	always_ff @(posedge core_clk) begin
		if (rst)
			rej_reg <= 1'b0;
		else if (wr_edge)
			rej_reg <= !accept;
	end

	// The running copy loads once, at the first edge after power-on reset.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			boot_reg <= 1'b1;
			run_addr_reg <= `FSL_ADDR_RESET;
			run_rate_reg <= `FSL_RATE_RESET;
		end else if (boot_reg) begin
			boot_reg <= 1'b0;
			run_addr_reg <= pend_addr_reg;
			run_rate_reg <= pend_rate_reg;
		end
	end

	// Address zero keeps the node silent; comms follow the running copy.
	logic comm_reg;
	always_ff @(posedge core_clk) begin
		if (rst)
			comm_reg <= 1'b0;
		else
			comm_reg <= (run_addr_reg != 7'h00) && !boot_reg;
	end

	// ----------------------------------------------------------------
	// Millisecond timebase
	// ----------------------------------------------------------------
	// One divider serves both LEDs, so their slots count the same tick; the tick
	// is registered so that both generators see it on the same edge.
	localparam logic [13:0] MS_CYC = 14'(`FSL_MS_CYCLES);
	logic [13:0] div_reg;
	logic tick_reg;
	wire logic div_wrap = (div_reg == MS_CYC - 14'd1);
	always_ff @(posedge core_clk) begin
		if (rst)
			div_reg <= 14'd0;
		else if (div_wrap)
			div_reg <= 14'd0;
		else
			div_reg <= div_reg + 14'd1;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			tick_reg <= 1'b0;
		else
			tick_reg <= div_wrap;
	end

	// ----------------------------------------------------------------
	// Status selection
	// ----------------------------------------------------------------
	// The guarding flag is sticky; a new event in the clearing cycle wins.
	logic guard_reg;
	always_ff @(posedge core_clk) begin
		if (rst)
			guard_reg <= 1'b0;
		else if (err_guard_event)
			guard_reg <= 1'b1;
		else if (err_guard_clear)
			guard_reg <= 1'b0;
	end
	// The run LED follows the network-management state alone.
	wire logic nmt_oper = (nmt_state == FSL_NMT_OPER);
	wire logic nmt_preop = (nmt_state == FSL_NMT_PREOP);
	wire logic nmt_stopped = (nmt_state == FSL_NMT_STOPPED);
	wire fsl_pat_t run_pat =
		nmt_oper ? FSL_PAT_ON :
		nmt_preop ? FSL_PAT_BLINK :
		nmt_stopped ? FSL_PAT_SINGLE : FSL_PAT_OFF;

	// The error LED shows the worst condition: bus-off, guarding, warning.
	wire fsl_pat_t err_pat =
		err_bus_off ? FSL_PAT_ON :
		guard_reg ? FSL_PAT_DOUBLE :
		err_warning ? FSL_PAT_SINGLE : FSL_PAT_OFF;

	// ----------------------------------------------------------------
	// LED pattern generators
	// ----------------------------------------------------------------
	// Each generator restarts its pattern on any change, so a new state shows at once.
	logic run_led_w, err_led_w;
	fsl_led_pattern u_run_led (
		.core_clk(core_clk),
		.rst(rst),
		.ms_tick(tick_reg),
		.pattern(run_pat),
		.led(run_led_w)
	);
	fsl_led_pattern u_err_led (
		.core_clk(core_clk),
		.rst(rst),
		.ms_tick(tick_reg),
		.pattern(err_pat),
		.led(err_led_w)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Every output comes straight from a register here or in a generator.
	assign active_address = run_addr_reg;
	assign active_rate = run_rate_reg;
	assign comm_enable = comm_reg;
	assign pending_address = pend_addr_reg;
	assign pending_rate = pend_rate_reg;
	assign cfg_pending = pend_reg;
	assign cfg_rejected = rej_reg;
	assign run_led = run_led_w;
	assign err_led = err_led_w;
endmodule // fsl_fieldbus_status
`default_nettype wire

/* fsl_status_sva.sv */
// Port assertions for the fieldbus status block.
// Assumes it is bound to fsl_fieldbus_status.
`timescale 1ns/1ps
`default_nettype none
module fsl_status_sva
	import fsl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic motor_stopped,
	input wire logic drive_locked,
	input wire fsl_nmt_t nmt_state,
	input wire logic err_bus_off,
	input wire logic [6:0] active_address,
	input wire logic [2:0] active_rate,
	input wire logic comm_enable,
	input wire logic [6:0] pending_address,
	input wire logic [2:0] pending_rate,
	input wire logic cfg_pending,
	input wire logic cfg_rejected,
	input wire logic run_led,
	input wire logic err_led
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	reset_vals_a: assert property ($fell(rst) |-> active_rate == 3'h3
		&& active_address == 7'h00 && !cfg_pending) else $error("reset values");
	comm_en_a: assert property (!$past(rst) && !$past(rst, 2)
		|-> comm_enable == (active_address != 7'h00)) else $error("comm enable");
	run_cfg_a: assert property (!$past(rst) && !$past(rst, 2)
		|-> $stable(active_address) && $stable(active_rate)) else $error("running changed");
	lock_a: assert property ($changed(pending_address) || $changed(pending_rate)
		|-> $past(motor_stopped, 3) && $past(drive_locked, 3)) else $error("unlocked write");
	rate_a: assert property (pending_rate != 3'h7 && active_rate != 3'h7)
		else $error("illegal rate");
	refuse_a: assert property ($rose(cfg_rejected)
		|-> $stable(pending_address) && $stable(pending_rate)) else $error("refused write");
	run_off_a: assert property (nmt_state == FSL_NMT_OFF && $past(nmt_state) == FSL_NMT_OFF
		&& !$past(rst) |-> !run_led) else $error("run led lit");
	run_on_a: assert property (nmt_state == FSL_NMT_OPER [*5] |-> run_led)
		else $error("run led dark");
	bus_off_a: assert property (err_bus_off [*5] |-> err_led)
		else $error("err led dark");
endmodule // fsl_status_sva
bind fsl_fieldbus_status fsl_status_sva i_sva (.core_clk, .rst, .motor_stopped, .drive_locked,
	.nmt_state, .err_bus_off, .active_address, .active_rate, .comm_enable, .pending_address,
	.pending_rate, .cfg_pending, .cfg_rejected, .run_led, .err_led);
`default_nettype wire

/* fsl_panel_view.sv */
// Operator view of the two panel LEDs: cycles each has stayed lit.
// Assumes a high LED output means lit.
`timescale 1ns/1ps
`default_nettype none
module fsl_panel_view (
	input wire logic core_clk,
	input wire logic run_led,
	input wire logic err_led,
	output int run_lit,
	output int err_lit
);
	always_ff @(posedge core_clk) begin
		run_lit <= run_led ? run_lit + 1 : 0;
		err_lit <= err_led ? err_lit + 1 : 0;
	end
endmodule // fsl_panel_view
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the fieldbus status block.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fsl_pkg::*;
	logic core_clk = 0, rst = 1, motor_stopped = 0, drive_locked = 0, cfg_write = 0;
	logic err_warning = 0, err_guard_event = 0, err_guard_clear = 0, err_bus_off = 0;
	logic [6:0] node_address_setting = 0, active_address, pending_address;
	logic [2:0] rate_setting = 0, active_rate, pending_rate;
	logic comm_enable, cfg_pending, cfg_rejected, run_led, err_led;
	fsl_nmt_t nmt_state = FSL_NMT_OFF;
	int run_lit, err_lit, error_cnt = 0, compares = 0;
	int exp_pa = 0, exp_pr = 3, exp_cp = 0, exp_aa = 0, exp_ar = 3;
	fsl_fieldbus_status i_dut (.core_clk, .rst, .motor_stopped, .drive_locked, .cfg_write,
		.node_address_setting, .rate_setting, .nmt_state, .err_warning, .err_guard_event,
		.err_guard_clear, .err_bus_off, .active_address, .active_rate, .comm_enable,
		.pending_address, .pending_rate, .cfg_pending, .cfg_rejected, .run_led, .err_led);
	fsl_panel_view i_view (.core_clk, .run_led, .err_led, .run_lit, .err_lit);
	initial forever #50 core_clk = ~core_clk;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		if (error_cnt == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// A power cycle applies the pending settings and clears the pending flag.
	task automatic power_cycle;
		rst = 1;
		cyc(12);
		rst = 0;
		cyc(3);
		{exp_aa, exp_ar, exp_cp} = {exp_pa, exp_pr, 32'h0};
		chk("act_addr", active_address, exp_aa);
		chk("act_rate", active_rate, exp_ar);
		chk("comm_en", comm_enable, exp_aa != 0);
		chk("pending", cfg_pending, exp_cp);
		chk("rejected", cfg_rejected, 1'b0);
	endtask
	task automatic cfg(input logic s, input logic l, input logic [2:0] r);
		logic [6:0] a;
		logic ok;
		a = 7'($urandom_range(127, 1));
		ok = s && l && r != 3'h7;
		{motor_stopped, drive_locked, node_address_setting, rate_setting} = {s, l, a, r};
		cyc(5);
		cfg_write = 1;
		cyc(6);
		cfg_write = 0;
		cyc(3);
		if (ok) {exp_pa, exp_pr, exp_cp} = {25'h0, a, 29'h0, r, 32'h1};
		chk("rejected", cfg_rejected, !ok);
		chk("pend_addr", pending_address, exp_pa);
		chk("pend_rate", pending_rate, exp_pr);
		chk("pending", cfg_pending, exp_cp);
		chk("act_addr", active_address, exp_aa);
		chk("act_rate", active_rate, exp_ar);
	endtask
	task automatic led(input fsl_nmt_t n, input logic [3:0] e, input logic xr, input logic xe);
		{err_bus_off, err_warning, err_guard_clear, err_guard_event} = e;
		nmt_state = n;
		cyc(1);
		{err_guard_clear, err_guard_event} = 2'h0;
		cyc(60);
		chk("run_led", run_lit > 50, xr);
		chk("err_led", err_lit > 50, xe);
	endtask
	initial begin
		#1_000_000;
		error_cnt++;
		close_out;
	end
	initial begin
		void'($urandom(32'h9CD2C27C));
		power_cycle();
		cfg(0, 0, 3'h1);
		for (int r = 0; r < 8; r++) cfg(1, 1, 3'(r));
		cfg(0, 1, 3'h2);
		cfg(1, 0, 3'h5);
		cfg(1, 1, 3'h6);
		power_cycle();
		cfg(0, 0, 3'h1);
		led(FSL_NMT_OFF, 4'h0, 0, 0);
		led(FSL_NMT_STOPPED, 4'h4, 1, 1);
		led(FSL_NMT_PREOP, 4'h1, 1, 1);
		led(FSL_NMT_OPER, 4'hC, 1, 1);
		led(FSL_NMT_OFF, 4'h2, 0, 0);
		led(FSL_NMT_STOPPED, 4'h3, 1, 1);
		led(FSL_NMT_OFF, 4'h2, 0, 0);
		close_out;
	end
endmodule // testbench
`default_nettype wire
